// File: hdl/dpd_config.sv
// Depth phase, de-aliasing and output content configuration with APB access
// Operation
// - Direction bit set gives phase rising with distance
// - Base frames add signed 13-bit phase offset
// - Unwrap enable combines two successive frames
// - Ratio code maps 2,4,..64,0,1
// - Sub-frame count field, reset 4, max 32
// - Alternate enable interleaves supplementary frames
// - Statistics bit selects statistics over flags
// - Supplementary frames add own signed offset
`timescale 1ns/1ps
module dpd_config
	import dpd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dpd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [12:0] supplementary_frame_phase_offset,
	input wire logic frame_start,
	input wire logic pix_valid,
	input wire logic [dpd_pkg::PHASE_W-1:0] pix_phase,
	input wire logic [dpd_pkg::AUX_W-1:0] pix_flags,
	input wire logic [dpd_pkg::AUX_W-1:0] pix_stats,
	output logic out_valid,
	output logic [dpd_pkg::PHASE_W-1:0] out_phase,
	output logic [dpd_pkg::PERIOD_W-1:0] out_period,
	output logic out_unwrapped,
	output logic [dpd_pkg::AUX_W-1:0] out_aux,
	output logic supplementary_frame,
	output logic [6:0] alt_freq_ratio,
	output logic [6:0] subframe_target
);
	import dpd_pkg::*;

	logic phase_dir;
	logic [OFS_W-1:0] base_frame_phase_offset;
	logic two_frame_unwrap_enable;
	logic [2:0] alternate_freq_ratio_sel;
	logic [6:0] supplementary_subframe_count;
	logic alternate_frame_enable;
	logic stats_enable;
	logic [PIX_AW-1:0] pix_addr;
	logic s1_valid;
	logic s1_supp;
	logic [PHASE_W-1:0] s1_phase;
	logic [AUX_W-1:0] s1_aux;
	logic [PIX_AW-1:0] s1_addr;
	logic [PHASE_W-1:0] mem_rd;
	logic acc_write;
	logic acc_setup;
	logic hit;
	logic [31:0] next_rdata;

	// Direction then wrap-around add; low 12 bits of two's complement suffice
	function automatic logic [PHASE_W-1:0] adj_phase(
		input logic [PHASE_W-1:0] raw,
		input logic dir,
		input logic [OFS_W-1:0] ofs
	);
		logic [PHASE_W-1:0] d;
		d = dir ? raw : ~raw;
		return d + ofs[PHASE_W-1:0];
	endfunction : adj_phase

	// Ratio of alternate to base modulation frequency
	function automatic logic [6:0] ratio_of(input logic [2:0] code);
		case (code)
			3'h6: return 7'h00;
			3'h7: return 7'h01;
			default: return 7'(7'h02 << code);
		endcase
	endfunction : ratio_of

	assign acc_write = psel & penable & pready & pwrite;
	assign acc_setup = psel & ~penable & ~pready;
	assign hit = (paddr == ADDR_PHASE_DIR_BASE_OFS) ||
		(paddr == ADDR_DEALIAS_ALT_CTRL) || (paddr == ADDR_OUTPUT_CONTENT_CTRL);

	// Readback puts the fixed fields back; stored bits are only live ones
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			ADDR_PHASE_DIR_BASE_OFS:
				next_rdata = {12'h000, phase_dir, 6'h00,
					base_frame_phase_offset};
			ADDR_DEALIAS_ALT_CTRL:
				next_rdata = {8'h00, KEEP_FIELD_VAL, two_frame_unwrap_enable,
					alternate_freq_ratio_sel, supplementary_subframe_count,
					alternate_frame_enable};
			ADDR_OUTPUT_CONTENT_CTRL:
				next_rdata = {8'h00, OUT_CTRL_FIXED[23:6], stats_enable,
					OUT_CTRL_FIXED[4:0]};
			default:
				next_rdata = 32'h0000_0000;
		endcase
	end

	// No wait states: answer is registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= acc_setup;
			pslverr <= acc_setup & ~hit;
			if (acc_setup && !pwrite)
				prdata <= next_rdata;
		end
	end

	// Phase direction and base offset register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_dir <= RST_PHASE_DIR;
			base_frame_phase_offset <= RST_OFFSET;
		end
		else if (acc_write && paddr == ADDR_PHASE_DIR_BASE_OFS)
		begin
			phase_dir <= pwdata[POS_PHASE_DIR];
			base_frame_phase_offset <= pwdata[OFS_W-1:0];
		end
	end

	// De-aliasing and alternate frame register; software owns
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			two_frame_unwrap_enable <= 1'b0;
			alternate_freq_ratio_sel <= RST_RATIO_SEL;
			supplementary_subframe_count <= RST_SUBFRAME;
			alternate_frame_enable <= 1'b0;
		end
		else if (acc_write && paddr == ADDR_DEALIAS_ALT_CTRL)
		begin
			two_frame_unwrap_enable <= pwdata[POS_UNWRAP_EN];
			alternate_freq_ratio_sel <= pwdata[POS_RATIO_SEL +: 3];
			supplementary_subframe_count <= pwdata[POS_SUBFRAME +: 7];
			alternate_frame_enable <= pwdata[POS_ALT_EN];
		end
	end

	// Output content register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stats_enable <= 1'b0;
		else if (acc_write && paddr == ADDR_OUTPUT_CONTENT_CTRL)
			stats_enable <= pwdata[POS_STATS_EN];
	end

	// Timing-generator settings; count clipped at its maximum
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			alt_freq_ratio <= 7'h02;
			subframe_target <= RST_SUBFRAME;
		end
		else
		begin
			alt_freq_ratio <= ratio_of(alternate_freq_ratio_sel);
			subframe_target <= (supplementary_subframe_count > MAX_SUBFRAME)
				? MAX_SUBFRAME : supplementary_subframe_count;
		end
	end

	// Frames alternate base/supplementary only while alternates are on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			supplementary_frame <= 1'b0;
		else if (frame_start)
			supplementary_frame <= alternate_frame_enable &
				~supplementary_frame;
	end

	// Pixel index within the frame, restarted by each frame start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pix_addr <= '0;
		else if (frame_start)
			pix_addr <= '0;
		else if (pix_valid && pix_addr != LAST_PIX)
			pix_addr <= pix_addr + 13'h0001;
	end

	// First stage: direction, frame-specific offset, aux select
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_valid <= 1'b0;
			s1_supp <= 1'b0;
			s1_phase <= '0;
			s1_aux <= '0;
			s1_addr <= '0;
		end
		else
		begin
			s1_valid <= pix_valid;
			s1_supp <= supplementary_frame;
			s1_addr <= pix_addr;
			if (pix_valid)
			begin
				s1_phase <= adj_phase(pix_phase, phase_dir,
					supplementary_frame ? supplementary_frame_phase_offset
					: base_frame_phase_offset);
				s1_aux <= stats_enable ? pix_stats : pix_flags;
			end
		end
	end

	// Supplementary phases kept so the next base frame can unwrap
	dpd_phase_mem u_mem (
		.pclk(pclk),
		.wr_en(s1_valid & s1_supp),
		.wr_addr(s1_addr),
		.wr_data(s1_phase),
		.rd_addr(pix_addr),
		.rd_data(mem_rd)
	);

	// Output stage; coarse period comes from the previous frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid <= 1'b0;
			out_phase <= '0;
			out_period <= '0;
			out_unwrapped <= 1'b0;
			out_aux <= '0;
		end
		else
		begin
			out_valid <= s1_valid;
			if (s1_valid)
			begin
				out_phase <= s1_phase;
				out_aux <= s1_aux;
				out_unwrapped <= two_frame_unwrap_enable & ~s1_supp;
				out_period <= (two_frame_unwrap_enable && !s1_supp)
					? mem_rd[PHASE_W-1 -: PERIOD_W] : '0;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence base_pix_s;
		pix_valid && !supplementary_frame;
	endsequence
	sequence supp_pix_s;
		pix_valid && supplementary_frame;
	endsequence

	pipe_delay_a: assert property (
		pix_valid |-> ##2 out_valid)
		else $error("pixel not delivered two cycles later");
	base_offset_a: assert property (
		base_pix_s |-> ##2 out_phase == PHASE_W'(($past(phase_dir, 2)
		? $past(pix_phase, 2) : ~$past(pix_phase, 2))
		+ $past(base_frame_phase_offset[PHASE_W-1:0], 2)))
		else $error("base frame phase offset wrong");
	supp_offset_a: assert property (
		supp_pix_s |-> ##2 out_phase == PHASE_W'(($past(phase_dir, 2)
		? $past(pix_phase, 2) : ~$past(pix_phase, 2))
		+ $past(supplementary_frame_phase_offset[PHASE_W-1:0], 2)))
		else $error("supplementary frame offset wrong");
	dir_rising_a: assert property (
		pix_valid && phase_dir && base_frame_phase_offset == '0 &&
		!supplementary_frame |-> ##2 out_phase == $past(pix_phase, 2))
		else $error("phase not rising with distance");
	aux_select_a: assert property (
		pix_valid |-> ##2 out_aux == ($past(stats_enable, 2)
		? $past(pix_stats, 2) : $past(pix_flags, 2)))
		else $error("statistics or flags not selected");
	alt_toggle_a: assert property (
		frame_start && alternate_frame_enable
		|=> supplementary_frame != $past(supplementary_frame))
		else $error("alternate frame not interleaved");
	alt_off_a: assert property (
		frame_start && !alternate_frame_enable |=> !supplementary_frame)
		else $error("supplementary frame without alternate enable");
	unwrap_base_a: assert property (
		base_pix_s |-> ##2 out_unwrapped == $past(two_frame_unwrap_enable))
		else $error("base pixel unwrap marking wrong");
	unwrap_supp_a: assert property (
		supp_pix_s |-> ##2 (!out_unwrapped && out_period == '0))
		else $error("supplementary pixel marked unwrapped");
	ratio_map_a: assert property (
		alternate_freq_ratio_sel == 3'h6 [*2] |-> alt_freq_ratio == 7'h00)
		else $error("ratio code six not zero");
	subframe_cap_a: assert property (
		subframe_target <= MAX_SUBFRAME)
		else $error("sub-frame count above maximum");
endmodule : dpd_config

// File: shared/dpd_pkg.sv
// Register map, field layout and sizes of the depth phase configuration block
package dpd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PHASE_DIR_BASE_OFS = 8'hf9;
	localparam logic [7:0] IDX_DEALIAS_ALT_CTRL = 8'hfb;
	localparam logic [7:0] IDX_OUTPUT_CONTENT_CTRL = 8'hfe;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_PHASE_DIR_BASE_OFS = {2'h0, IDX_PHASE_DIR_BASE_OFS, 2'h0};
	localparam logic [11:0] ADDR_DEALIAS_ALT_CTRL = {2'h0, IDX_DEALIAS_ALT_CTRL, 2'h0};
	localparam logic [11:0] ADDR_OUTPUT_CONTENT_CTRL = {2'h0, IDX_OUTPUT_CONTENT_CTRL, 2'h0};
	// Phase direction / base offset register
	localparam int POS_PHASE_DIR = 19;
	localparam int OFS_W = 13;
	localparam logic RST_PHASE_DIR = 1'h1;
	localparam logic [12:0] RST_OFFSET = 13'h0000;
	// De-aliasing / alternate frame register
	localparam int POS_KEEP_FIELD = 12;
	localparam logic [11:0] KEEP_FIELD_VAL = 12'h01e;
	localparam int POS_UNWRAP_EN = 11;
	localparam int POS_RATIO_SEL = 8;
	localparam int POS_SUBFRAME = 1;
	localparam int POS_ALT_EN = 0;
	localparam logic [6:0] RST_SUBFRAME = 7'h04;
	localparam logic [6:0] MAX_SUBFRAME = 7'h20;
	localparam logic [2:0] RST_RATIO_SEL = 3'h0;
	// Output content register
	localparam int POS_STATS_EN = 5;
	localparam logic [23:0] OUT_CTRL_FIXED = 24'h21090f;
	localparam logic [31:0] SECOND_REG_RESET = 32'h0001e008;
	// Pixel array and data widths
	localparam int PHASE_W = 12;
	localparam int AUX_W = 4;
	localparam int PIX_COUNT = 4800;
	localparam int PIX_AW = 13;
	localparam logic [12:0] LAST_PIX = 13'h12bf;
	localparam int PERIOD_W = 4;
endpackage : dpd_pkg

// File: hdl/dpd_phase_mem.sv
// Phase store holding one supplementary frame, registered read port
`timescale 1ns/1ps
module dpd_phase_mem
	import dpd_pkg::*;
(
	input wire logic pclk,
	input wire logic wr_en,
	input wire logic [dpd_pkg::PIX_AW-1:0] wr_addr,
	input wire logic [dpd_pkg::PHASE_W-1:0] wr_data,
	input wire logic [dpd_pkg::PIX_AW-1:0] rd_addr,
	output logic [dpd_pkg::PHASE_W-1:0] rd_data
);
	logic [PHASE_W-1:0] mem [0:PIX_COUNT-1];

	// No reset on the array, so it maps onto block memory
	always_ff @(posedge pclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Read data always comes from a register
	always_ff @(posedge pclk)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule : dpd_phase_mem

// File: tb/testbench.sv
// Self-checking bench for the depth phase configuration block
`timescale 1ns/1ps
module testbench;
	import dpd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [12:0] sup_ofs = 13'h0007;
	logic frame_start = 1'b0;
	logic pix_valid = 1'b0;
	logic [11:0] pix_phase = 12'h000;
	logic [3:0] pix_flags = 4'h3;
	logic [3:0] pix_stats = 4'hc;
	logic out_valid;
	logic [11:0] out_phase;
	logic [3:0] out_period;
	logic out_unwrapped;
	logic [3:0] out_aux;
	logic supplementary_frame;
	logic [6:0] alt_freq_ratio;
	logic [6:0] subframe_target;
	int fail_count = 0;
	int check_count = 0;
	logic [31:0] rdat;
	logic rerr;

	dpd_config i_dpd_config (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supplementary_frame_phase_offset(sup_ofs),
		.frame_start(frame_start), .pix_valid(pix_valid),
		.pix_phase(pix_phase), .pix_flags(pix_flags), .pix_stats(pix_stats),
		.out_valid(out_valid), .out_phase(out_phase),
		.out_period(out_period), .out_unwrapped(out_unwrapped),
		.out_aux(out_aux), .supplementary_frame(supplementary_frame),
		.alt_freq_ratio(alt_freq_ratio), .subframe_target(subframe_target));

	// Free-running 100 MHz clock
	always #5 pclk = ~pclk;

	task automatic end_sim;
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] s, x);
		check_count++;
		if (s !== x)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			fail_count++;
			end_sim();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("read data", rdat, x);
	endtask : rd

	// Frame marker pulse, then settle
	task automatic fs;
		@(posedge pclk);
		frame_start <= 1'b1;
		@(posedge pclk);
		frame_start <= 1'b0;
		@(posedge pclk);
		#1;
	endtask : fs

	// One pixel; judges corrected phase and side data
	task automatic pix(input logic [11:0] raw, ep, input logic [3:0] ea);
		int n;
		@(posedge pclk);
		pix_valid <= 1'b1;
		pix_phase <= raw;
		@(posedge pclk);
		pix_valid <= 1'b0;
		for (n = 0; n < 6; n++)
		begin
			@(posedge pclk);
			#1;
			if (out_valid === 1'b1)
				break;
		end
		chk("out_valid", out_valid, 1'b1);
		chk("out_phase", out_phase, ep);
		chk("out_aux", out_aux, ea);
	endtask : pix

	// Reset values and fixed fields
	task automatic t_reset;
		chk("ratio", alt_freq_ratio, 7'h02);
		chk("target", subframe_target, 7'h04);
		rd(ADDR_PHASE_DIR_BASE_OFS, 32'h00080000);
		rd(ADDR_DEALIAS_ALT_CTRL, 32'h0001e008);
		rd(ADDR_OUTPUT_CONTENT_CTRL, 32'h0021090f);
		pix(12'h064, 12'h064, 4'h3);
		apb(1'b0, 12'h3f0, 32'h0);
		chk("slverr", rerr, 1'b1);
	endtask : t_reset

	// Offset write with direction clear, and fixed fields rewritten unchanged, read back
	task automatic t_fields;
		apb(1'b1, ADDR_PHASE_DIR_BASE_OFS, 32'h00001ffb);
		rd(ADDR_PHASE_DIR_BASE_OFS, 32'h00001ffb);
		apb(1'b1, ADDR_OUTPUT_CONTENT_CTRL, 32'h0021090f);
		rd(ADDR_OUTPUT_CONTENT_CTRL, 32'h0021090f);
	endtask : t_fields

	// Every ratio code, then sub-frame count clipping
	task automatic t_ratio;
		logic [6:0] x;
		for (int c = 0; c < 8; c++)
		begin
			x = (c < 6) ? (7'h02 << c) : ((c == 6) ? 7'h00 : 7'h01);
			apb(1'b1, ADDR_DEALIAS_ALT_CTRL, 32'h1e008 | (c << 8));
			@(posedge pclk);
			#1;
			chk("ratio", alt_freq_ratio, x);
		end
		apb(1'b1, ADDR_DEALIAS_ALT_CTRL, 32'h1e080);
		@(posedge pclk);
		#1;
		chk("target", subframe_target, 7'h20);
	endtask : t_ratio

	// Direction, base offset and side data selection
	task automatic t_pixel;
		pix(12'h064, 12'hf96, 4'h3);
		apb(1'b1, ADDR_OUTPUT_CONTENT_CTRL, 32'h0021092f);
		rd(ADDR_OUTPUT_CONTENT_CTRL, 32'h0021092f);
		apb(1'b1, ADDR_PHASE_DIR_BASE_OFS, 32'h00081ffb);
		pix(12'h064, 12'h05f, 4'hc);
	endtask : t_pixel

	// Alternate frames with unwrap across a frame pair
	task automatic t_alt;
		apb(1'b1, ADDR_DEALIAS_ALT_CTRL, 32'h0001ea11);
		rd(ADDR_DEALIAS_ALT_CTRL, 32'h0001ea11);
		fs();
		chk("supp", supplementary_frame, 1'b1);
		pix(12'ha00, 12'ha07, 4'hc);
		chk("unwrapped", out_unwrapped, 1'b0);
		fs();
		chk("supp", supplementary_frame, 1'b0);
		pix(12'ha00, 12'h9fb, 4'hc);
		chk("unwrapped", out_unwrapped, 1'b1);
		chk("period", out_period, 4'ha);
		apb(1'b1, ADDR_DEALIAS_ALT_CTRL, 32'h0001e008);
		fs();
		chk("supp", supplementary_frame, 1'b0);
	endtask : t_alt

	// Main sequence
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		t_reset();
		t_fields();
		t_ratio();
		t_pixel();
		t_alt();
		end_sim();
	end
endmodule : testbench
